// ### hw/panel_ctrl.v
// Purpose: front-panel switch, lamp and backplane fail/reset logic
// Assumes: all inputs synchronous to clk_i; classic Wishbone slave
// Notes:
// Notes on behaviour
// (R1) Enabled reset press: local reset, plus system reset; logic drives system reset only when jumper fitted
// (R2) Debounced reset gated by software enable bit
// (R3) Remote reset contacts act like the button
// (R4) Debounced abort drives level seven interrupt
// (R5) Acknowledge cycle returns abort vector
// (R6) Abort ignored while its enable bit clear
// (R7) Fail lamp: fail flag or watchdog timeout
// (R8) Fail drives backplane fail unless inhibited
// (R9) Fail flag set at reset, software writable
// (R10) Status lamp lit while status pin low
// (R11) Cache-only running shows normal, not full, brightness
// (R12) Run lamp follows address strobe
// (R13) Controller lamp lit when system controller
// (R14) Jumper fitted enables system controller functions
// (R15) Operator avoids reset while non-controller runs cycles
// (R16) Stable-for-N debounce, one event per press
// (R17) Abort request held until acknowledged or cleared
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`include "panel_map.vh"

module panel_ctrl
#(
    parameter [`PNL_DEB_W-1:0] DEB_CYC = `PNL_DEB_CYC
)
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Switches and jumper, active high when pressed or fitted
    input  wire        reset_pushbutton_i,
    input  wire        remote_reset_connector_i,
    input  wire        abort_pushbutton_i,
    input  wire        controller_select_jumper_i,
    // Processor side
    input  wire        status_n_i,
    input  wire        address_strobe_n_i,
    input  wire        cache_only_i,
    input  wire        iack_i,
    input  wire [2:0]  iack_level_i,
    input  wire        wdog_timeout_i,
    output reg         ipl7_req_o,
    output reg  [7:0]  iack_vector_o,
    output reg         iack_vector_oe_o,
    // Resets out
    output reg         local_reset_o,
    output reg         sys_reset_o,
    // Backplane fail, open drain, oe low drives low
    output wire        sysfail_o,
    output wire        sysfail_oe_n_o,
    // Lamps
    output reg         fail_lamp_o,
    output reg         status_lamp_o,
    output reg         status_bright_o,
    output reg         run_lamp_o,
    output reg         controller_lamp_o,
    // Interrupt
    output wire        irq_o
);

// Control register
reg  [3:0] ctrl_r;
reg  [`PNL_EV_W-1:0] ena_r;
wire rst_en       = ctrl_r[`PNL_RST_EN_BIT];
wire abt_en       = ctrl_r[`PNL_ABT_EN_BIT];
wire board_fail_flag = ctrl_r[`PNL_FAIL_BIT];
wire inhibit      = ctrl_r[`PNL_INHIBIT_BIT];

// Jumper is sampled each cycle, so a change takes effect one cycle later
reg        syscon_r;

// Debounced switches; only the press pulses are used here
wire rst_press;
wire rem_press;
wire abt_press;

switch_debounce #(.HOLD(DEB_CYC)) u_deb_reset
(
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (reset_pushbutton_i),
    .level_o (),
    .press_o (rst_press)
);

switch_debounce #(.HOLD(DEB_CYC)) u_deb_remote
(
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (remote_reset_connector_i),
    .level_o (),
    .press_o (rem_press)
);

switch_debounce #(.HOLD(DEB_CYC)) u_deb_abort
(
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (abort_pushbutton_i),
    .level_o (),
    .press_o (abt_press)
);

// Reset-out: stretched pulse so downstream logic sees a full reset
wire       any_reset_press = (rst_press | rem_press) & rst_en; // (R2) (R3)
wire       rst_stretch;
reg  [7:0] rst_cnt_r;
reg  [7:0] rst_cnt_nxt;
reg        local_reset_nxt;
reg        sys_reset_nxt;

assign rst_stretch = (rst_cnt_r != 8'h00);

always @*
begin
    rst_cnt_nxt = rst_cnt_r;
    if (any_reset_press)
        rst_cnt_nxt = `PNL_RSTOUT_CYC;
    else if (rst_stretch)
        rst_cnt_nxt = rst_cnt_r - 8'h01;
    // Press cycle counts too, so the pulse is one longer than the count
    local_reset_nxt = any_reset_press | rst_stretch; // (R1)
    // Backplane reset only while this board owns the backplane
    sys_reset_nxt   = local_reset_nxt & syscon_r; // (R1) (R14)
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        rst_cnt_r     <= 8'h00;
        local_reset_o <= 1'b0;
        sys_reset_o   <= 1'b0;
    end
    else
    begin
        rst_cnt_r     <= rst_cnt_nxt;
        local_reset_o <= local_reset_nxt;
        sys_reset_o   <= sys_reset_nxt;
    end
end

// Abort request, held pending until acknowledged or cleared
wire abort_ack = iack_i & (iack_level_i == `PNL_ABORT_LEVEL) & ipl7_req_o;
wire sw_clr_abort;
reg        ipl7_req_nxt;
reg        iack_vector_oe_nxt;
reg  [7:0] iack_vector_nxt;

always @*
begin
    ipl7_req_nxt = ipl7_req_o;
    // A press wins over a clear in the same cycle, so it is never lost
    if (abt_press & abt_en) // (R4) (R6)
        ipl7_req_nxt = 1'b1;
    else if (abort_ack | sw_clr_abort | ~abt_en) // (R17)
        ipl7_req_nxt = 1'b0;
    iack_vector_oe_nxt = abort_ack; // (R5)
    iack_vector_nxt    = abort_ack ? `PNL_ABORT_VECTOR : 8'h00; // (R5)
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ipl7_req_o       <= 1'b0;
        iack_vector_o    <= 8'h00;
        iack_vector_oe_o <= 1'b0;
    end
    else
    begin
        ipl7_req_o       <= ipl7_req_nxt;
        iack_vector_oe_o <= iack_vector_oe_nxt;
        iack_vector_o    <= iack_vector_nxt;
    end
end

// Events and interrupt
wire [`PNL_EV_W-1:0] ev_set;
wire [`PNL_EV_W-1:0] ev_clr;
wire [`PNL_EV_W-1:0] ev_stat;
reg                  wdog_d_r;

assign ev_set[`PNL_EV_RESET_BIT] = rst_press | rem_press;
assign ev_set[`PNL_EV_ABORT_BIT] = abt_press & abt_en;
assign ev_set[`PNL_EV_WDOG_BIT]  = wdog_timeout_i & ~wdog_d_r;

event_latch u_events
(
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (ev_set),
    .clr_i  (ev_clr),
    .ena_i  (ena_r),
    .stat_o (ev_stat),
    .irq_o  (irq_o)
);

// Lamps and backplane fail
wire fail_cond = board_fail_flag | wdog_timeout_i; // (R7)

assign sysfail_o      = 1'b0;
assign sysfail_oe_n_o = ~(fail_lamp_o & ~inhibit); // (R8)

reg fail_lamp_nxt;
reg status_lamp_nxt;
reg status_bright_nxt;
reg run_lamp_nxt;
reg controller_lamp_nxt;

always @*
begin
    fail_lamp_nxt       = fail_cond; // (R7)
    status_lamp_nxt     = ~status_n_i; // (R10)
    // Full brightness only when halted, not while running from cache
    status_bright_nxt   = ~status_n_i & ~cache_only_i; // (R10) (R11)
    run_lamp_nxt        = ~address_strobe_n_i; // (R12)
    controller_lamp_nxt = controller_select_jumper_i; // (R13)
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wdog_d_r          <= 1'b0;
        syscon_r          <= 1'b0;
        fail_lamp_o       <= 1'b1;
        status_lamp_o     <= 1'b0;
        status_bright_o   <= 1'b0;
        run_lamp_o        <= 1'b0;
        controller_lamp_o <= 1'b0;
    end
    else
    begin
        wdog_d_r          <= wdog_timeout_i;
        syscon_r          <= controller_select_jumper_i; // (R14)
        fail_lamp_o       <= fail_lamp_nxt;
        status_lamp_o     <= status_lamp_nxt;
        status_bright_o   <= status_bright_nxt;
        run_lamp_o        <= run_lamp_nxt;
        controller_lamp_o <= controller_lamp_nxt;
    end
end

// Wishbone slave: one wait state, ack drops after one cycle
wire req   = cyc_i & stb_i & ~ack_o;
wire wr    = req & we_i & sel_i[0];
wire wr_ct = wr & (adr_i == `PNL_CTRL_OFF);
wire wr_en = wr & (adr_i == `PNL_ENA_OFF);
wire wr_cl = wr & (adr_i == `PNL_CLR_OFF);

assign ev_clr       = wr_cl ? dat_i[`PNL_EV_W-1:0] : {`PNL_EV_W{1'b0}};
assign sw_clr_abort = wr_cl & dat_i[`PNL_EV_ABORT_BIT];

reg [3:0]           ctrl_nxt;
reg [`PNL_EV_W-1:0] ena_nxt;

always @*
begin
    ctrl_nxt = ctrl_r;
    ena_nxt  = ena_r;
    // Fail flag is plain read-write, so software may set it again
    if (wr_ct)
        ctrl_nxt = dat_i[3:0]; // (R9)
    if (wr_en)
        ena_nxt = dat_i[`PNL_EV_W-1:0];
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ctrl_r <= `PNL_CTRL_RESET; // (R9)
        ena_r  <= {`PNL_EV_W{1'b0}};
    end
    else
    begin
        ctrl_r <= ctrl_nxt;
        ena_r  <= ena_nxt;
    end
end

reg [31:0] rd_nxt;

always @*
begin
    rd_nxt = 32'h0000_0000;
    case (adr_i)
        `PNL_CTRL_OFF:
            rd_nxt[3:0] = ctrl_r;
        `PNL_STAT_OFF:
        begin
            rd_nxt[`PNL_EV_W-1:0]      = ev_stat;
            rd_nxt[`PNL_LVL_SYSCON_BIT] = syscon_r;
            rd_nxt[`PNL_LVL_FAIL_BIT]   = fail_lamp_o;
            rd_nxt[`PNL_LVL_ABTP_BIT]   = ipl7_req_o;
        end
        `PNL_ENA_OFF:
            rd_nxt[`PNL_EV_W-1:0] = ena_r;
        default:
            rd_nxt = 32'h0000_0000;
    endcase
end

// Read data only in the ack cycle, zero otherwise
wire        ack_nxt = req;
wire [31:0] dat_nxt = (req & ~we_i) ? rd_nxt : 32'h0000_0000;

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_o <= 1'b0;
        dat_o <= 32'h0000_0000;
    end
    else
    begin
        ack_o <= ack_nxt;
        dat_o <= dat_nxt;
    end
end

endmodule // panel_ctrl

// ### hw/panel_map.vh
// Purpose: constants for the front-panel control block
// Assumes: 20 MHz clock, Wishbone word addressing on byte offsets
// Notes:   included by the panel logic files
`ifndef PANEL_MAP_VH
`define PANEL_MAP_VH

// Register byte offsets
`define PNL_CTRL_OFF       4'h0
`define PNL_STAT_OFF       4'h4
`define PNL_ENA_OFF        4'h8
`define PNL_CLR_OFF        4'hC

// Control register fields
`define PNL_RST_EN_BIT     0
`define PNL_ABT_EN_BIT     1
`define PNL_FAIL_BIT       2
`define PNL_INHIBIT_BIT    3
`define PNL_CTRL_RESET     4'h5

// Event bits, shared by status, enable and clear
`define PNL_EV_RESET_BIT   0
`define PNL_EV_ABORT_BIT   1
`define PNL_EV_WDOG_BIT    2
`define PNL_EV_W           3

// Level read-back in status word
`define PNL_LVL_SYSCON_BIT 8
`define PNL_LVL_FAIL_BIT   9
`define PNL_LVL_ABTP_BIT   10

// Abort interrupt
`define PNL_ABORT_LEVEL    3'h7
`define PNL_ABORT_VECTOR   8'h40

// Debounce time in microseconds, clock in MHz
`define PNL_DEB_US         10000
`define PNL_CLK_MHZ        20
`define PNL_DEB_CYC        (`PNL_DEB_US * `PNL_CLK_MHZ)
`define PNL_DEB_W          18

// Reset pulse stretch
`define PNL_RSTOUT_CYC     8'h10

`endif

// ### hw/switch_debounce.v
// Purpose: debounce one active-high switch input, one pulse per press
// Assumes: input synchronous to clk_i
// Notes:   level changes only after HOLD stable cycles
`timescale 1ns/100ps
`include "panel_map.vh"

module switch_debounce
#(
    parameter [`PNL_DEB_W-1:0] HOLD = `PNL_DEB_CYC
)
(
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Switch
    input  wire raw_i,
    // Cleaned outputs
    output wire level_o,
    output wire press_o
);

reg [`PNL_DEB_W-1:0] cnt_r;
reg                  level_r;
reg                  press_r;

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        cnt_r   <= {`PNL_DEB_W{1'b0}};
        level_r <= 1'b0;
        press_r <= 1'b0;
    end
    else
    begin
        press_r <= 1'b0;
        if (raw_i == level_r)
            cnt_r <= {`PNL_DEB_W{1'b0}};
        else if (cnt_r >= HOLD - 1'b1) // (R16)
        begin
            cnt_r   <= {`PNL_DEB_W{1'b0}};
            level_r <= raw_i;
            press_r <= raw_i; // (R16)
        end
        else
            cnt_r <= cnt_r + 1'b1;
    end
end

assign level_o = level_r;
assign press_o = press_r;

endmodule // switch_debounce

// ### hw/event_latch.v
// Purpose: sticky event bits with enable mask and write-one clear
// Assumes: set and clear in the same cycle, set wins
// Notes:   irq_o is a level
`timescale 1ns/100ps
`include "panel_map.vh"

module event_latch
(
    // Clock and reset
    input  wire                 clk_i,
    input  wire                 rst_i,
    // Events and software
    input  wire [`PNL_EV_W-1:0] set_i,
    input  wire [`PNL_EV_W-1:0] clr_i,
    input  wire [`PNL_EV_W-1:0] ena_i,
    // State
    output wire [`PNL_EV_W-1:0] stat_o,
    output wire                 irq_o
);

reg [`PNL_EV_W-1:0] stat_r;

always @(posedge clk_i)
begin
    if (rst_i)
        stat_r <= {`PNL_EV_W{1'b0}};
    else
        stat_r <= (stat_r & ~clr_i) | set_i;
end

assign stat_o = stat_r;
assign irq_o  = |(stat_r & ena_i);

endmodule // event_latch

// ### dv/switch_model.sv
// Purpose: chattering contacts of reset, remote reset and abort
// Assumes: closed_i from the bench, bit 0 reset, 1 remote, 2 abort
// Notes:   each change chatters three cycles before it settles
`timescale 1ns/100ps
module switch_model
(
    // Clock
    input  wire       clk_i,
    // Wanted and seen contact state
    input  wire [2:0] closed_i,
    output reg  [2:0] contact_o
);
    reg [2:0] last_r = 3'h0;
    reg [2:0] diff_r = 3'h0;
    reg [1:0] chat_r = 2'h0;
    initial contact_o = 3'h0;
    always @(posedge clk_i)
    begin
        last_r <= closed_i;
        if (closed_i != last_r)
        begin
            chat_r <= 2'h3;
            diff_r <= closed_i ^ last_r;
        end
        else if (chat_r != 2'h0)
            chat_r <= chat_r - 2'h1;
        // Bounce only the changed contacts
        contact_o <= (chat_r != 2'h0) ? contact_o ^ diff_r : closed_i;
    end
endmodule // switch_model

// ### dv/panel_chk.sv
// Purpose: port checks for the front-panel control block
// Assumes: one clock domain, lamps registered one cycle
// Notes:   bound to every panel_ctrl instance
`timescale 1ns/100ps
module panel_chk
(
    // Clock and reset
    input wire       clk_i,
    input wire       rst_i,
    // Inputs watched
    input wire       we_i,
    input wire       iack_i,
    input wire       status_n_i,
    input wire       address_strobe_n_i,
    input wire       cache_only_i,
    input wire       controller_select_jumper_i,
    input wire       wdog_timeout_i,
    // Outputs watched
    input wire       ipl7_req_o,
    input wire [7:0] iack_vector_o,
    input wire       iack_vector_oe_o,
    input wire       local_reset_o,
    input wire       sysfail_o,
    input wire       sysfail_oe_n_o,
    input wire       fail_lamp_o,
    input wire       status_lamp_o,
    input wire       status_bright_o,
    input wire       run_lamp_o,
    input wire       controller_lamp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_fail; $past(wdog_timeout_i) |-> fail_lamp_o; endproperty
    a_fail: assert property (p_fail) else $error("fail lamp dark");
    property p_sf; !sysfail_oe_n_o |-> fail_lamp_o && !sysfail_o; endproperty
    a_sf: assert property (p_sf) else $error("stray backplane fail");
    property p_stat; !$past(rst_i) |-> status_lamp_o == !$past(status_n_i); endproperty
    a_stat: assert property (p_stat) else $error("status lamp wrong");
    property p_brt;
        !$past(rst_i) |-> status_bright_o == !$past(status_n_i || cache_only_i);
    endproperty
    a_brt: assert property (p_brt) else $error("brightness wrong");
    property p_run; !$past(rst_i) |-> run_lamp_o != $past(address_strobe_n_i); endproperty
    a_run: assert property (p_run) else $error("run lamp wrong");
    property p_con;
        !$past(rst_i) |-> controller_lamp_o == $past(controller_select_jumper_i);
    endproperty
    a_con: assert property (p_con) else $error("controller lamp wrong");
    property p_vec;
        iack_vector_oe_o |-> iack_vector_o == 8'h40 && ($past(iack_i) || $past(iack_i, 2));
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_hold; ipl7_req_o && !iack_i && !we_i |=> ipl7_req_o; endproperty
    a_hold: assert property (p_hold) else $error("abort request lost");
    property p_rst; $rose(local_reset_o) |-> local_reset_o [*8]; endproperty
    a_rst: assert property (p_rst) else $error("reset pulse short");
    c_rst: cover property ($rose(local_reset_o));
    c_vec: cover property (iack_vector_oe_o);
    c_sf: cover property ($fell(sysfail_oe_n_o));
endmodule // panel_chk
bind panel_ctrl panel_chk panel_chk_inst (.*);

// ### dv/front_panel_switch_lamp_logic_test.sv
// Purpose: self-checking bench for the front-panel control block
// Assumes: debounce cut to 4 cycles, 50 ns clock
// Notes:   switches pass through the chattering contact model
`timescale 1ns/100ps
module front_panel_switch_lamp_logic_test;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, iack_i, cache_only_i, wdog_timeout_i;
    logic        status_n_i, address_strobe_n_i, controller_select_jumper_i;
    logic [3:0]  adr_i, sel_i, seen;
    logic [31:0] dat_i, rd;
    logic [2:0]  iack_level_i, closed;
    wire  [31:0] dat_o;
    wire  [7:0]  iack_vector_o;
    wire         ack_o, ipl7_req_o, iack_vector_oe_o, local_reset_o, sys_reset_o, irq_o;
    wire         sysfail_o, sysfail_oe_n_o, fail_lamp_o, status_lamp_o, status_bright_o;
    wire         run_lamp_o, controller_lamp_o;
    wire         reset_pushbutton_i, remote_reset_connector_i, abort_pushbutton_i;
    int          n_mismatch = 0;
    int          checked = 0;

    panel_ctrl #(.DEB_CYC(18'h4)) panel_ctrl_inst (.*);
    switch_model switch_model_inst
    (
        .clk_i     (clk_i),
        .closed_i  (closed),
        .contact_o ({abort_pushbutton_i, remote_reset_connector_i, reset_pushbutton_i})
    );
    always #25 clk_i = ~clk_i;

    task chk(string s, logic [31:0] v, logic [31:0] e);
        checked++;
        if (v !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, e, v);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task wb(logic w, logic [3:0] a, logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++t < 20);
        rd = dat_o;
        if (t >= 20) n_mismatch++;
        {cyc_i, stb_i} <= 2'b00;
    endtask

    function logic [3:0] exp_press(logic [2:0] m, logic [1:0] en, logic j);
        logic r;
        r = (m[0] | m[1]) & en[0];
        return {r, r & j, {2{m[2] & en[1]}}};
    endfunction

    // Sampled inside the 17-cycle reset pulse
    task press(logic [2:0] m);
        @(posedge clk_i);
        closed <= m;
        repeat (14) @(posedge clk_i);
        @(negedge clk_i);
        seen = {local_reset_o, sys_reset_o, ipl7_req_o, irq_o};
        @(posedge clk_i);
        closed <= 3'h0;
        repeat (40) @(posedge clk_i);
    endtask

    initial
    begin
        {clk_i, rst_i, cyc_i, stb_i, we_i, iack_i, cache_only_i, wdog_timeout_i} = 8'h40;
        {status_n_i, address_strobe_n_i, controller_select_jumper_i} = 3'h7;
        {adr_i, sel_i, dat_i, iack_level_i, closed} = {4'h0, 4'hF, 32'h0, 3'h7, 3'h0};
        void'($urandom(93669));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 4'h0, 0);
        chk("ctrl", rd, 32'h5);
        @(negedge clk_i);
        chk("fail", {fail_lamp_o, sysfail_oe_n_o, sysfail_o}, 3'h4);
        repeat (30)
        begin
            @(posedge clk_i);
            {status_n_i, address_strobe_n_i, cache_only_i, wdog_timeout_i,
             controller_select_jumper_i} <= 5'($urandom);
        end
        @(posedge clk_i);
        {wdog_timeout_i, controller_select_jumper_i} <= 2'b01;
        press(3'h1);
        chk("rst btn", seen, exp_press(3'h1, 2'b01, 1'b1));
        // Non-controller press; address strobe keeps its last random value, so traffic is not excluded
        controller_select_jumper_i <= 1'b0;
        press(3'h2);
        chk("rst remote", seen, exp_press(3'h2, 2'b01, 1'b0));
        wb(1, 4'hC, 32'h7);
        wb(1, 4'h0, 32'h4);
        press(3'h1);
        chk("rst off", seen, exp_press(3'h1, 2'b00, 1'b0));
        wb(0, 4'h4, 0);
        chk("rst event", rd[0], 1'b1);
        wb(1, 4'h0, 32'h2);
        wb(1, 4'h8, 32'h2);
        @(negedge clk_i);
        chk("flag off", fail_lamp_o, 1'b0);
        press(3'h4);
        chk("abort", seen, exp_press(3'h4, 2'b10, 1'b0));
        iack_i <= 1'b1;
        @(posedge clk_i);
        iack_i <= 1'b0;
        rd = 0;
        repeat (3)
        begin
            @(posedge clk_i);
            if (iack_vector_oe_o === 1'b1) rd = {24'h0, iack_vector_o};
        end
        chk("vector", {rd[7:0], ipl7_req_o}, {8'h40, 1'b0});
        wb(1, 4'hC, 32'h2);
        @(negedge clk_i);
        chk("irq clr", irq_o, 1'b0);
        wb(1, 4'h0, 32'h0);
        press(3'h4);
        chk("abort off", seen, exp_press(3'h4, 2'b00, 1'b0));
        wdog_timeout_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("wdog", {fail_lamp_o, sysfail_oe_n_o}, 2'b10);
        wb(1, 4'h0, 32'hC);
        wb(0, 4'h2, 0);
        chk("unmapped", rd, 32'h0);
        @(negedge clk_i);
        chk("inhibit", {fail_lamp_o, sysfail_oe_n_o}, 2'b11);
        final_report;
    end

    initial
    begin
        #400000;
        n_mismatch++;
        final_report;
    end
endmodule // front_panel_switch_lamp_logic_test
